// ---- src/bsf_pkg.sv ----
/*
  Shared constants and types for the bitstream framer, extractor and
  encapsulation header generator.
  Assumes one 200 MHz clock and synchronous active-low reset.
*/
package bsf_pkg;
  localparam int VC_W = 6;
  localparam int NVC = 64;
  localparam int LEN_W = 14;
  localparam int GOS_W = 2;
  localparam int FILL_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = VC_W + 1;
  localparam logic [LEN_W-1:0] PTR_ALL_FILL = 14'h3FFE;
  localparam int PCID_W = 11;
  localparam int NPCID = 2048;
  localparam logic [PCID_W-1:0] PCID_IP = 11'h7FE;
  localparam int SEQ_W = 14;
  localparam int PLEN_W = 16;
  localparam int HDR_W = 48;
  localparam logic [2:0] HDR_VERSION = 3'h0;
  localparam logic HDR_SEC_FLAG = 1'b0;
  localparam logic [1:0] HDR_SEQ_FLAGS = 2'h3;
  localparam int HDR_VER_LSB = 45;
  localparam int HDR_TYPE_POS = 44;
  localparam int HDR_SEC_POS = 43;
  localparam int HDR_PCID_LSB = 32;
  localparam int HDR_SEQF_LSB = 30;
  localparam int HDR_SEQC_LSB = 16;
  localparam int HDR_PLEN_LSB = 0;
  typedef enum logic [1:0] {
    BSF_IDLE = 2'b00,
    BSF_DATA = 2'b01,
    BSF_FILL = 2'b10
  } bsf_state_type;
endpackage

// ---- src/bsf_top.sv ----
/*
  Bitstream frame builder with input FIFO, bit extractor with loss flag,
  and encapsulation primary header generator.
  Assumes all inputs are synchronous to clk; management writes the frame
  length and grade of service of a channel before the channel carries data.
*/
// How it works
// - each frame carries one channel only
// - user bits copied in order, unaltered
// - frame length fixed per channel by management
// - full frame continues into next frame
// - early release pads with fill pattern
// - pointer marks last valid data bit
// - frames leave with the channel's grade of service
// - extracted bits go to frame's channel
// - fill bits dropped using the pointer
// - loss flag follows channel-access frame loss
// - loss flag held until valid data delivered
// - header version bits are 000
// - header type bit set by parameter
// - secondary header flag is zero
// - eleven-bit packet channel id field
// - internet payload uses all-ones-minus-one id
// - sequence flags are 11
// - fourteen-bit sequence count wraps at 16384
// - one counter per packet channel
// - length field is octets minus one
`timescale 1ns/10ps

module bsf_fifo #(
  parameter int W = 1,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic full_reg, full_next, push, pop;

  always_comb
  begin
    push = in_valid && !full_reg;
    pop = out_valid && out_ready;
    wptr_next = push ? AW'((int'(wptr_reg) + 1) % D) : wptr_reg;
    rptr_next = pop ? AW'((int'(rptr_reg) + 1) % D) : rptr_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    full_next = (cnt_next == (AW+1)'(D));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      full_reg <= 1'b0;
    end
    else
    begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
      full_reg <= full_next;
    end
    if (push)
      mem[wptr_reg] <= in_data;
  end

  assign in_ready = !full_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rptr_reg];
endmodule

////////////////////////////////////////////////////////////////////////////////

module bsf_top #(
  parameter logic TYPE_BIT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // management configuration
  input wire logic cfg_wr,
  input wire logic [bsf_pkg::VC_W-1:0] cfg_vc,
  input wire logic [bsf_pkg::LEN_W-1:0] cfg_len,
  input wire logic [bsf_pkg::GOS_W-1:0] cfg_gos,
  input wire logic [bsf_pkg::FILL_W-1:0] fill_pattern,
  // bitstream user, send side
  input wire logic in_valid,
  input wire logic in_bit,
  input wire logic [bsf_pkg::VC_W-1:0] in_vc,
  output logic in_ready,
  input wire logic release_req,
  // frames to channel access
  output logic out_valid,
  input wire logic out_ready,
  output logic out_bit,
  output logic out_first,
  output logic out_last,
  output logic [bsf_pkg::LEN_W-1:0] out_pointer,
  output logic [bsf_pkg::VC_W-1:0] out_vc,
  output logic [bsf_pkg::GOS_W-1:0] out_gos,
  // frames from channel access
  input wire logic rx_valid,
  input wire logic rx_bit,
  input wire logic rx_first,
  input wire logic rx_last,
  input wire logic [bsf_pkg::LEN_W-1:0] rx_pointer,
  input wire logic [bsf_pkg::VC_W-1:0] rx_vc,
  input wire logic rx_loss,
  // bitstream user, receive side
  output logic usr_valid,
  output logic usr_bit,
  output logic [bsf_pkg::VC_W-1:0] usr_vc,
  output logic usr_loss,
  // encapsulation header
  input wire logic hdr_req,
  input wire logic [bsf_pkg::PCID_W-1:0] hdr_pcid,
  input wire logic hdr_is_ip,
  input wire logic [bsf_pkg::PLEN_W:0] hdr_octets,
  output logic hdr_valid,
  output logic [bsf_pkg::HDR_W-1:0] hdr_word
);
  import bsf_pkg::*;

  logic [LEN_W-1:0] len_mem [NVC];
  logic [GOS_W-1:0] gos_mem [NVC];
  logic f_valid, f_ready, f_ready_w;
  logic [FIFO_W-1:0] f_data;

  always_ff @(posedge clk)
  begin
    if (cfg_wr)
    begin
      len_mem[cfg_vc] <= cfg_len;
      gos_mem[cfg_vc] <= cfg_gos;
    end
  end

  bsf_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_data({in_vc, in_bit}),
    .in_ready(f_ready_w),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );
  assign in_ready = f_ready_w;

  //////////////////////////////////////////////////////////////////////////////
  // frame builder
  bsf_state_type st_reg, st_next;
  logic [LEN_W-1:0] cnt_reg, cnt_next, len_reg, len_next, ptr_reg, ptr_next;
  logic [VC_W-1:0] vc_reg, vc_next;
  logic [GOS_W-1:0] gos_reg, gos_next;
  logic rel_reg, rel_next, slot_free, rel_any, other_vc, at_end;
  logic ov_reg, ov_next, ob_reg, ob_next, of_reg, of_next, ol_reg, ol_next;
  logic [LEN_W-1:0] op_reg, op_next;
  logic [VC_W-1:0] ovc_reg, ovc_next;
  logic [GOS_W-1:0] og_reg, og_next;

  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    ptr_next = ptr_reg;
    vc_next = vc_reg;
    gos_next = gos_reg;
    slot_free = !ov_reg || out_ready;
    rel_any = rel_reg || release_req;
    rel_next = rel_any;
    other_vc = f_data[FIFO_W-1:1] != vc_reg;
    at_end = (cnt_reg == len_reg - LEN_W'(1));
    f_ready = 1'b0;
    ov_next = ov_reg && !out_ready;
    ob_next = ob_reg;
    of_next = of_reg;
    ol_next = ol_reg;
    op_next = op_reg;
    ovc_next = ovc_reg;
    og_next = og_reg;
    case (st_reg)
      BSF_IDLE:
      begin
        rel_next = 1'b0;
        if (f_valid)
        begin
          vc_next = f_data[FIFO_W-1:1];
          len_next = len_mem[f_data[FIFO_W-1:1]];
          gos_next = gos_mem[f_data[FIFO_W-1:1]];
          cnt_next = '0;
          st_next = BSF_DATA;
        end
      end
      BSF_DATA:
      begin
        if (slot_free && (rel_any || (f_valid && other_vc)))
        begin
          rel_next = 1'b0;
          ptr_next = (cnt_reg == '0) ? PTR_ALL_FILL : cnt_reg - LEN_W'(1);
          st_next = BSF_FILL;
        end
        else if (slot_free && f_valid)
        begin
          f_ready = 1'b1;
          ov_next = 1'b1;
          ob_next = f_data[0];
          of_next = (cnt_reg == '0);
          ol_next = at_end;
          op_next = len_reg - LEN_W'(1);
          ovc_next = vc_reg;
          og_next = gos_reg;
          cnt_next = at_end ? '0 : cnt_reg + LEN_W'(1);
          st_next = at_end ? BSF_IDLE : BSF_DATA;
        end
      end
      BSF_FILL:
      begin
        rel_next = 1'b0;
        if (slot_free)
        begin
          ov_next = 1'b1;
          ob_next = fill_pattern[3'h7 - cnt_reg[2:0]];
          of_next = (cnt_reg == '0);
          ol_next = at_end;
          op_next = ptr_reg;
          ovc_next = vc_reg;
          og_next = gos_reg;
          cnt_next = at_end ? '0 : cnt_reg + LEN_W'(1);
          st_next = at_end ? BSF_IDLE : BSF_FILL;
        end
      end
      default:
        st_next = BSF_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= BSF_IDLE;
      cnt_reg <= '0;
      len_reg <= '0;
      ptr_reg <= '0;
      vc_reg <= '0;
      gos_reg <= '0;
      rel_reg <= 1'b0;
      ov_reg <= 1'b0;
      ob_reg <= 1'b0;
      of_reg <= 1'b0;
      ol_reg <= 1'b0;
      op_reg <= '0;
      ovc_reg <= '0;
      og_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      ptr_reg <= ptr_next;
      vc_reg <= vc_next;
      gos_reg <= gos_next;
      rel_reg <= rel_next;
      ov_reg <= ov_next;
      ob_reg <= ob_next;
      of_reg <= of_next;
      ol_reg <= ol_next;
      op_reg <= op_next;
      ovc_reg <= ovc_next;
      og_reg <= og_next;
    end
  end

  assign out_valid = ov_reg;
  assign out_bit = ob_reg;
  assign out_first = of_reg;
  assign out_last = ol_reg;
  assign out_pointer = op_reg;
  assign out_vc = ovc_reg;
  assign out_gos = og_reg;

  //////////////////////////////////////////////////////////////////////////////
  // extractor; one loss flag shared by all channels
  logic [LEN_W-1:0] rc_reg, rc_next, rp_reg, rp_next, r_idx, r_ptr;
  logic uv_reg, uv_next, ub_reg, ub_next, ul_reg, ul_next, lp_reg, lp_next;
  logic [VC_W-1:0] uvc_reg, uvc_next, rv_reg, rv_next, r_vc;
  logic keep, lost_now;

  always_comb
  begin
    r_ptr = rx_first ? rx_pointer : rp_reg;
    r_idx = rx_first ? '0 : rc_reg;
    // channel id only stands with the first bit, so hold it for the frame
    r_vc = rx_first ? rx_vc : rv_reg;
    keep = rx_valid && (r_ptr != PTR_ALL_FILL) && (r_idx <= r_ptr);
    lost_now = rx_valid && rx_first && rx_loss;
    rp_next = rx_valid ? r_ptr : rp_reg;
    rc_next = rx_valid ? (rx_last ? '0 : r_idx + LEN_W'(1)) : rc_reg;
    uv_next = keep;
    ub_next = keep ? rx_bit : ub_reg;
    rv_next = rx_valid ? r_vc : rv_reg;
    uvc_next = keep ? r_vc : uvc_reg;
    ul_next = keep ? (lp_reg || lost_now) : ul_reg;
    lp_next = keep ? 1'b0 : (lp_reg || lost_now);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rc_reg <= '0;
      rp_reg <= '0;
      uv_reg <= 1'b0;
      ub_reg <= 1'b0;
      ul_reg <= 1'b0;
      lp_reg <= 1'b0;
      uvc_reg <= '0;
      rv_reg <= '0;
    end
    else
    begin
      rc_reg <= rc_next;
      rp_reg <= rp_next;
      uv_reg <= uv_next;
      ub_reg <= ub_next;
      ul_reg <= ul_next;
      lp_reg <= lp_next;
      uvc_reg <= uvc_next;
      rv_reg <= rv_next;
    end
  end

  assign usr_valid = uv_reg;
  assign usr_bit = ub_reg;
  assign usr_vc = uvc_reg;
  assign usr_loss = ul_reg;

  //////////////////////////////////////////////////////////////////////////////
  // header generator; counters cleared on reset so every channel starts at 0
  logic [SEQ_W-1:0] seq_mem [NPCID];
  logic [PCID_W-1:0] pc_eff;
  logic [SEQ_W-1:0] seq_cur;
  logic hv_reg, hv_next;
  logic [HDR_W-1:0] hw_reg, hw_next;

  always_comb
  begin
    pc_eff = hdr_is_ip ? PCID_IP : hdr_pcid;
    seq_cur = seq_mem[pc_eff];
    hv_next = hdr_req;
    hw_next = hw_reg;
    if (hdr_req)
    begin
      hw_next[HDR_VER_LSB+:3] = HDR_VERSION;
      hw_next[HDR_TYPE_POS] = TYPE_BIT;
      hw_next[HDR_SEC_POS] = HDR_SEC_FLAG;
      hw_next[HDR_PCID_LSB+:PCID_W] = pc_eff;
      hw_next[HDR_SEQF_LSB+:2] = HDR_SEQ_FLAGS;
      hw_next[HDR_SEQC_LSB+:SEQ_W] = seq_cur;
      hw_next[HDR_PLEN_LSB+:PLEN_W] = PLEN_W'(hdr_octets - 17'h00001);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hv_reg <= 1'b0;
      hw_reg <= '0;
      for (int i = 0; i < NPCID; i++)
        seq_mem[i] <= '0;
    end
    else
    begin
      hv_reg <= hv_next;
      hw_reg <= hw_next;
      if (hdr_req)
        seq_mem[pc_eff] <= seq_cur + SEQ_W'(1);
    end
  end

  assign hdr_valid = hv_reg;
  assign hdr_word = hw_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // length captured at the first beat: len_reg may already hold the next frame's
  logic [LEN_W-1:0] beats_reg, flen_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      beats_reg <= '0;
      flen_reg <= '0;
    end
    else
    begin
      if (ov_reg && out_ready)
        beats_reg <= ol_reg ? '0 : beats_reg + LEN_W'(1);
      if (slot_free && ov_next && of_next)
        flen_reg <= len_reg;
    end
  end

  sequence s_req_same;
    hdr_req && !hdr_is_ip ##1 hdr_req && !hdr_is_ip && $stable(hdr_pcid);
  endsequence
  sequence s_early_release;
    st_reg == BSF_DATA && slot_free && rel_any;
  endsequence
  sequence s_lost_fill;
    rx_valid && rx_first && rx_loss && rx_pointer == PTR_ALL_FILL;
  endsequence

  hdr_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
    hdr_req |=> hdr_word[47:45] == 3'h0 && hdr_word[31:30] == 2'h3)
    else $error("fixed header bits wrong");
  sec_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    hdr_valid |-> !hdr_word[43]) else $error("secondary flag set");
  ip_pcid_a: assert property (@(posedge clk) disable iff (!rst_n)
    hdr_req && hdr_is_ip |=> hdr_word[42:32] == 11'h7FE) else $error("ip id wrong");
  seq_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_req_same |=> hdr_word[29:16] == $past(hdr_word[29:16]) + 14'h0001)
    else $error("sequence count not stepped");
  plen_a: assert property (@(posedge clk) disable iff (!rst_n)
    hdr_req |=> hdr_word[15:0] == 16'($past(hdr_octets) - 17'h00001))
    else $error("length field wrong");
  frame_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid && out_ready && out_last |-> beats_reg == flen_reg - 14'h0001)
    else $error("frame length mismatch");
  release_fill_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_early_release |=> st_reg == BSF_FILL ##1 out_valid && out_first == ($past(cnt_reg, 2) == '0))
    else $error("release did not start fill");
  drop_fill_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_valid && rx_first && rx_pointer == PTR_ALL_FILL |=> !usr_valid)
    else $error("fill bit delivered");
  loss_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_lost_fill |=> lp_reg) else $error("loss flag dropped");
endmodule

// ---- tb/bsf_chan_model.sv ----
/*
  Channel-access model: takes built frames with random stalls and loops each
  whole frame back to the extractor, optionally with an all-fill lost frame.
  Assumes the bench pulses fill_loss only while no frame is in flight.
*/
`timescale 1ns/10ps

module bsf_chan_model (
  // clock and bench control
  input wire logic clk,
  input wire logic hold,
  input wire logic slow,
  input wire logic fill_loss,
  // frames from the builder
  input wire logic out_valid,
  output logic out_ready,
  input wire logic out_bit,
  input wire logic out_first,
  input wire logic out_last,
  input wire logic [bsf_pkg::LEN_W-1:0] out_pointer,
  input wire logic [bsf_pkg::VC_W-1:0] out_vc,
  // frames to the extractor
  output logic rx_valid,
  output logic rx_bit,
  output logic rx_first,
  output logic rx_last,
  output logic [bsf_pkg::LEN_W-1:0] rx_pointer,
  output logic [bsf_pkg::VC_W-1:0] rx_vc,
  output logic rx_loss
);
  import bsf_pkg::*;
  logic [2:0] stage[$];
  logic [2:0] beats[$];
  logic [20:0] heads[$];
  logic [2:0] b;
  logic [20:0] h;
  logic [15:0] lfsr;

  initial
  begin
    {out_ready, rx_valid, rx_bit, rx_first, rx_last, rx_pointer, rx_vc, rx_loss} = '0;
    lfsr = 16'hACE1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    out_ready <= !hold && (!slow || lfsr[0]);
    if (out_valid && out_ready)
    begin
      stage.push_back({out_first, out_last, out_bit});
      // whole frames only: the pointer is known at the last beat
      if (out_last)
      begin
        heads.push_back({1'b0, out_vc, out_pointer});
        foreach (stage[i]) beats.push_back(stage[i]);
        stage.delete();
      end
    end
    if (fill_loss)
    begin
      heads.push_back({1'b1, 6'h00, PTR_ALL_FILL});
      for (int i = 0; i < 8; i++) beats.push_back({i == 0, i == 7, i[0]});
    end
    if (beats.size() > 0)
    begin
      b = beats.pop_front();
      rx_valid <= 1'b1;
      {rx_first, rx_last, rx_bit} <= b;
      if (b[2])
      begin
        h = heads.pop_front();
        {rx_loss, rx_vc, rx_pointer} <= h;
      end
      else
        {rx_loss, rx_vc, rx_pointer} <= ~{rx_loss, rx_vc, rx_pointer};
    end
    else
    begin
      {rx_valid, rx_first, rx_last} <= 3'h0;
      {rx_bit, rx_loss, rx_vc, rx_pointer} <= ~{rx_bit, rx_loss, rx_vc, rx_pointer};
    end
  end
endmodule

// ---- tb/testbench.sv ----
/*
  Self-checking bench: streams, releases, fifo stall, loss flag, headers.
  Assumes the design package and the channel-access model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module testbench;
  import bsf_pkg::*;
  logic clk, rst_n, cfg_wr, in_valid, in_bit, in_ready, release_req, hold, slow, fill_loss;
  logic [VC_W-1:0] cfg_vc, in_vc, out_vc, rx_vc, usr_vc;
  logic [LEN_W-1:0] cfg_len, out_pointer, rx_pointer;
  logic [GOS_W-1:0] cfg_gos, out_gos, gos_of [NVC];
  logic [FILL_W-1:0] fill_pattern;
  logic out_valid, out_ready, out_bit, out_first, out_last;
  logic rx_valid, rx_bit, rx_first, rx_last, rx_loss, usr_valid, usr_bit, usr_loss;
  logic hdr_req, hdr_is_ip, hdr_valid;
  logic [PCID_W-1:0] hdr_pcid;
  logic [PLEN_W:0] hdr_octets;
  logic [HDR_W-1:0] hdr_word;
  logic [SEQ_W-1:0] seqc [NPCID];
  logic dq[$];
  logic [8:0] uq[$];
  logic [35:0] nq[$];
  logic [HDR_W-1:0] hq[$];
  logic fb [0:63];
  logic [31:0] seed = 32'hE15A65BD;
  int len_of [NVC];
  int fail_count = 0, n_checks = 0, beats = 0, fidx = 0, refused = 0;
  logic loss_exp = 1'b0;

  bsf_top #(.TYPE_BIT(1'b1)) i_dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .cfg_vc(cfg_vc), .cfg_len(cfg_len), .cfg_gos(cfg_gos), .fill_pattern(fill_pattern),
    .in_valid(in_valid), .in_bit(in_bit), .in_vc(in_vc), .in_ready(in_ready),
    .release_req(release_req), .out_valid(out_valid), .out_ready(out_ready),
    .out_bit(out_bit), .out_first(out_first), .out_last(out_last),
    .out_pointer(out_pointer), .out_vc(out_vc), .out_gos(out_gos), .rx_valid(rx_valid),
    .rx_bit(rx_bit), .rx_first(rx_first), .rx_last(rx_last), .rx_pointer(rx_pointer),
    .rx_vc(rx_vc), .rx_loss(rx_loss), .usr_valid(usr_valid), .usr_bit(usr_bit),
    .usr_vc(usr_vc), .usr_loss(usr_loss), .hdr_req(hdr_req), .hdr_pcid(hdr_pcid),
    .hdr_is_ip(hdr_is_ip), .hdr_octets(hdr_octets), .hdr_valid(hdr_valid),
    .hdr_word(hdr_word));
  bsf_chan_model i_chan (.clk(clk), .hold(hold), .slow(slow), .fill_loss(fill_loss),
    .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit),
    .out_first(out_first), .out_last(out_last), .out_pointer(out_pointer),
    .out_vc(out_vc), .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_first(rx_first),
    .rx_last(rx_last), .rx_pointer(rx_pointer), .rx_vc(rx_vc), .rx_loss(rx_loss));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task finish_test();
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task send_bit(input int vc);
    logic [31:0] r;
    bit ok;
    int k;
    r = rnd();
    in_valid <= 1'b1;
    in_bit <= r[0];
    in_vc <= 6'(vc);
    ok = 0;
    for (k = 0; k < 500 && !ok; k++)
    begin
      @(negedge clk) ok = in_ready;
      refused += !ok;
      @(posedge clk);
    end
    if (!ok)
    begin
      fail_count++;
      finish_test();
    end
    dq.push_back(r[0]);
    uq.push_back({1'b0, loss_exp, 6'(vc), r[0]});
    loss_exp = 1'b0;
  endtask

  task wait_beats(input int t);
    int k;
    k = 0;
    while (beats < t && k < 2000)
    begin
      @(negedge clk);
      k++;
    end
    if (beats < t)
    begin
      fail_count++;
      finish_test();
    end
  endtask

  // whole frames carry len-1 pointers, a partial one is closed by a release pulse
  task send_stream(input int vc, input int n);
    int base, l;
    base = beats;
    l = len_of[vc];
    for (int i = 0; i < n / l; i++) nq.push_back({14'(l), 14'(l - 1), 6'(vc), gos_of[vc]});
    if (n % l) nq.push_back({14'(l), 14'(n % l - 1), 6'(vc), gos_of[vc]});
    @(posedge clk);
    for (int i = 0; i < n; i++) send_bit(vc);
    in_valid <= 1'b0;
    wait_beats(base + n);
    if (n % l)
    begin
      @(posedge clk) release_req <= 1'b1;
      @(posedge clk) release_req <= 1'b0;
      wait_beats(base + (n / l + 1) * l);
    end
  endtask

  task set_vc(input int vc, input int l, input logic [1:0] g);
    len_of[vc] = l;
    gos_of[vc] = g;
    @(posedge clk);
    {cfg_wr, cfg_vc, cfg_len, cfg_gos} <= {1'b1, 6'(vc), 14'(l), g};
    @(posedge clk) cfg_wr <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk)
  begin
    logic [35:0] e;
    logic [8:0] u;
    logic [HDR_W-1:0] w;
    logic d;
    if (usr_valid)
    begin
      u = 9'h1FF;
      if (uq.size() > 0) u = uq.pop_front();
      `CHK({1'b0, usr_loss, usr_vc, usr_bit}, u)
    end
    if (hdr_valid)
    begin
      w = ~hdr_word;
      if (hq.size() > 0) w = hq.pop_front();
      `CHK(hdr_word, w)
    end
    if (out_valid && out_ready)
    begin
      beats++;
      `CHK(out_first, fidx == 0)
      fb[fidx] = out_bit;
      if (out_last)
      begin
        e = '1;
        if (nq.size() > 0) e = nq.pop_front();
        `CHK(14'(fidx + 1), e[35:22])
        `CHK({out_pointer, out_vc, out_gos}, e[21:0])
        for (int i = 0; i <= fidx; i++)
        begin
          d = ~fb[i];
          if (i <= int'(e[21:8]) && dq.size() > 0) d = dq.pop_front();
          if (i > int'(e[21:8])) d = fill_pattern[7 - i % 8];
          `CHK(fb[i], d)
        end
      end
      fidx = out_last ? 0 : fidx + 1;
    end
  end

  initial
  begin
    logic [31:0] r;
    logic ip;
    logic [PCID_W-1:0] pc, id;
    logic [PLEN_W:0] oc;
    int k;
    {rst_n, cfg_wr, cfg_vc, cfg_len, cfg_gos, fill_pattern, in_valid, in_bit, in_vc} = '0;
    {release_req, hdr_req, hdr_pcid, hdr_is_ip, hdr_octets, hold, slow, fill_loss} = '0;
    foreach (seqc[i]) seqc[i] = 14'h0000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({in_ready, out_valid, usr_valid, hdr_valid}, 4'h8)
    r = rnd();
    @(posedge clk) fill_pattern <= r[7:0];
    set_vc(5, 13, 2'h2);
    set_vc(63, 1, 2'h1);
    set_vc(0, 40, 2'h3);
    send_stream(5, 30);
    slow <= 1'b1;
    send_stream(63, 5);
    // builder stalled: the fifo must refuse before the hold lifts
    hold <= 1'b1;
    fork
      begin
        repeat (60) @(posedge clk);
        hold <= 1'b0;
      end
    join_none
    send_stream(0, 20);
    `CHK(refused > 0, 1'b1)
    for (k = 0; k < 2000 && uq.size() > 0; k++) @(posedge clk);
    if (uq.size() > 0)
    begin
      fail_count++;
      finish_test();
    end
    @(posedge clk) fill_loss <= 1'b1;
    @(posedge clk) fill_loss <= 1'b0;
    loss_exp = 1'b1;
    send_stream(5, 10);
    slow <= 1'b0;
    for (int i = 0; i < 22000; i++)
    begin
      @(posedge clk);
      r = rnd();
      ip = (r[2:0] == 3'h1);
      pc = (r[2:0] == 3'h0) ? r[15:5] : 11'h003;
      oc = {1'b0, r[31:16]} + 17'h00001;
      id = ip ? 11'h7FE : pc;
      hq.push_back({3'h0, 1'b1, 1'b0, id, 2'h3, seqc[id], 16'(oc - 17'h00001)});
      seqc[id] = seqc[id] + 14'h0001;
      {hdr_req, hdr_pcid, hdr_is_ip, hdr_octets} <= {1'b1, pc, ip, oc};
    end
    @(posedge clk) hdr_req <= 1'b0;
    for (k = 0; k < 2000 && uq.size() + hq.size() + nq.size() + dq.size() > 0; k++)
      @(posedge clk);
    if (k == 2000) fail_count++;
    finish_test();
  end
endmodule
